// ===== bench/pos_host_model.sv
/*
 Host processor model: raises power hold a boot delay after reset release.
 Assumes the bench sets the wanted hold level and the boot delay.
*/
module pos_host_model (
   input  logic        clk,
   input  logic        rst_n,
   input  logic        sys_reset_out_n,
   input  logic        want_hold,
   input  logic [15:0] boot_cyc,
   output logic        power_hold_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt;
   // In reset the processor pin floats and the board pull-down wins
   always @(posedge clk) begin
      if (!rst_n || !sys_reset_out_n) begin
         cnt <= 16'h0000;
         power_hold_in <= 1'b0;
      end else if (cnt < boot_cyc) begin
         cnt <= cnt + 16'h0001;
      end else begin
         power_hold_in <= want_hold;
      end
   end
endmodule // pos_host_model

// ===== bench/pos_supervisor_properties.sv
/*
 Checker for the on/off supervisor: port timing of APB, reset output,
 regulator enables, interrupt pin and GPIO drivers.
 Assumes it is bound to pos_supervisor and a write lands at the access edge.
*/
`include "pos_map.vh"

module pos_supervisor_properties (
   input logic        clk,
   input logic        rst_n,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        pslverr,
   input logic        irq_out_n_oe_n,
   input logic        sys_reset_out_n_oe_n,
   input logic [3:0]  reg_enable,
   input logic        gpio_out,
   input logic        gpio_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr_acc;
   logic unmasked;
   assign wr_acc = psel && penable && pready && pwrite;
   // Remembers any unmasking write; until then the pin must stay released
   always @(posedge clk) begin
      if (!rst_n)
         unmasked <= 1'b0;
      else if (wr_acc && paddr == `POS_REG_MASK && pwdata[4:0] != 5'h1F)
         unmasked <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_all_on;
      reg_enable == 4'hF;
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_gpio_wr;
      wr_acc && paddr == `POS_REG_GPIO;
   endsequence
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_zero_wait: assert property (s_setup |=> pready)
      else $error("ready missing after setup");
   a_bad_addr: assert property (s_setup and paddr == 12'h020 |=> pslverr)
      else $error("no error for unmapped address");
   a_masked_quiet: assert property (!unmasked |-> irq_out_n_oe_n)
      else $error("interrupt pin moved while all masked");
   a_release_all_on: assert property ($rose(sys_reset_out_n_oe_n) |-> s_all_on ##0 $past(reg_enable[3], 2))
      else $error("reset released before last regulator settled");
   a_reset_lead: assert property ($fell(sys_reset_out_n_oe_n) |-> s_all_on [*3])
      else $error("regulator dropped right after reset asserted");
   a_off_in_reset: assert property (reg_enable < $past(reg_enable) |-> !$past(sys_reset_out_n_oe_n))
      else $error("regulator off while reset released");
   a_input_only: assert property (s_gpio_wr and pwdata[0] |-> ##2 gpio_oe_n)
      else $error("gpio drives while input");
   a_push_pull: assert property (s_gpio_wr and pwdata[1:0] == 2'b10 |->
      ##2 (!gpio_oe_n && gpio_out == $past(pwdata[2], 2)))
      else $error("push-pull drive wrong");
   a_open_drain: assert property (s_gpio_wr and pwdata[1:0] == 2'b00 |->
      ##2 (gpio_oe_n == $past(pwdata[2], 2)))
      else $error("open-drain drive wrong");
endmodule // pos_supervisor_properties

bind pos_supervisor pos_supervisor_properties i_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .irq_out_n_oe_n, .sys_reset_out_n_oe_n, .reg_enable, .gpio_out, .gpio_oe_n);

// ===== bench/test_pos_supervisor.sv
/*
 Testbench of the on/off supervisor: wake sources, hold, soft commands,
 bias enable, GPIO drive, edge interrupts and debounce.
 Assumes shortened timer parameters; the hold filter stays at full length.
*/
`include "pos_map.vh"

module test_pos_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, onkey_n, host_hold, glitch;
   logic charge_input, irq_out_n_oe_n, sys_reset_out_n_oe_n, main_bias_on, gpio_ext, gpio_out, gpio_oe_n, want_hold;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, seed;
   logic [3:0]  reg_enable, c;
   logic [15:0] boot_cyc;
   logic [1:0]  m;
   logic        e;
   int          mismatches, compares, i;
   wire         gpio_in = gpio_oe_n ? gpio_ext : gpio_out;
   wire         power_hold_in = host_hold & ~glitch;

   pos_supervisor #(.DBNC_CYC(8), .CHG_CYC(8), .MRST_CYC(64), .HWAIT_CYC(4000), .STEP_CYC(4)) i_dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .onkey_n(onkey_n),
      .power_hold_in(power_hold_in), .charge_input(charge_input), .irq_out_n_oe_n(irq_out_n_oe_n),
      .sys_reset_out_n_oe_n(sys_reset_out_n_oe_n), .reg_enable(reg_enable), .main_bias_on(main_bias_on),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
   pos_host_model i_host (.clk(clk), .rst_n(rst_n), .sys_reset_out_n(sys_reset_out_n_oe_n),
      .want_hold(want_hold), .boot_cyc(boot_cyc), .power_hold_in(host_hold));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Driver released only for input, or for open-drain high
   function logic exp_oe(input logic [3:0] k);
      return k[0] | (!k[1] & k[2]);
   endfunction
   function logic exp_pin(input logic [3:0] k);
      return exp_oe(k) ? k[3] : k[2];
   endfunction

   task tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         mismatches++;
         tally_and_finish();
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000, r, e);
   endtask
   // Bounded wait on the reset pin (sel 0) or the regulator enables (sel 1)
   task wait_pin(input logic sel, input logic [3:0] v, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge clk);
         if ((sel ? reg_enable : {3'h0, sys_reset_out_n_oe_n}) === v)
            break;
      end
      if (n == lim) begin
         mismatches++;
         tally_and_finish();
      end
   endtask
   task key_press;
      onkey_n <= 1'b0;
      cyc(20);
      onkey_n <= 1'b1;
      wait_pin(1'b0, 4'h1, 300);
   endtask

   initial begin
      {psel, penable, pwrite, glitch, charge_input, want_hold, rst_n} = 7'h00;
      {onkey_n, gpio_ext} = 2'b11;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      seed = 32'h0000_037d;
      boot_cyc = 16'h0005;
      mismatches = 0;
      compares = 0;
      cyc(2);
      rst_n <= 1'b1;
      rd(`POS_REG_MASK);
      check(r[4:0], 5'h1F);
      rd(`POS_REG_CTRL);
      check(r[0], 1'b0);
      apb(1'b0, 12'h020, 32'h0000_0000, r, e);
      check(e, 1'b1);
      $display("test reset values done");
      want_hold <= 1'b1;
      key_press();
      check(reg_enable, 4'hF);
      cyc(4200);
      check(sys_reset_out_n_oe_n, 1'b1);
      rd(`POS_REG_STATUS);
      check(r[5], 1'b1);
      glitch <= 1'b1;
      cyc(200);
      glitch <= 1'b0;
      cyc(3000);
      check(sys_reset_out_n_oe_n, 1'b1);
      onkey_n <= 1'b0;
      wait_pin(1'b0, 4'h0, 300);
      wait_pin(1'b1, 4'h0, 100);
      check(reg_enable, 4'h0);
      onkey_n <= 1'b1;
      cyc(20);
      boot_cyc <= 16'(rnd() % 1000 + 500);
      key_press();
      cyc(4200);
      want_hold <= 1'b0;
      wait_pin(1'b0, 4'h0, 3000);
      wait_pin(1'b1, 4'h0, 100);
      check(reg_enable, 4'h0);
      key_press();
      cyc(3800);
      check(sys_reset_out_n_oe_n, 1'b1);
      wait_pin(1'b0, 4'h0, 500);
      wait_pin(1'b1, 4'h0, 100);
      $display("test key and hold done");
      charge_input <= 1'b1;
      wait_pin(1'b0, 4'h1, 300);
      cyc(4200);
      check(sys_reset_out_n_oe_n, 1'b1);
      rd(`POS_REG_STATUS);
      check(r[6:5], 2'b11);
      wr(`POS_REG_CTRL, 32'h0000_000C);
      wait_pin(1'b0, 4'h0, 50);
      wait_pin(1'b1, 4'h0, 100);
      wr(`POS_REG_CTRL, 32'h0000_0004);
      wait_pin(1'b0, 4'h1, 300);
      wr(`POS_REG_CTRL, 32'h0000_0008);
      wait_pin(1'b0, 4'h0, 50);
      wait_pin(1'b0, 4'h1, 300);
      charge_input <= 1'b0;
      wait_pin(1'b0, 4'h0, 300);
      wait_pin(1'b1, 4'h0, 100);
      $display("test charger and soft commands done");
      // Slide-switch: key stays low while on; high for the manual-reset time powers down
      boot_cyc <= 16'h0005;
      want_hold <= 1'b1;
      onkey_n <= 1'b0;
      wait_pin(1'b0, 4'h1, 300);
      wr(`POS_REG_CTRL, 32'h0000_0001);
      cyc(4200);
      check(sys_reset_out_n_oe_n, 1'b1);
      onkey_n <= 1'b1;
      wait_pin(1'b0, 4'h0, 300);
      wait_pin(1'b1, 4'h0, 100);
      want_hold <= 1'b0;
      wr(`POS_REG_CTRL, 32'h0000_0000);
      $display("test slide switch done");
      // Slave style: bias only, no soft commands, nothing else left on
      wr(`POS_REG_CTRL, 32'h0000_0002);
      cyc(5);
      check(main_bias_on, 1'b1);
      wr(`POS_REG_CTRL, 32'h0000_0000);
      cyc(5);
      check(main_bias_on, 1'b0);
      $display("test bias done");
      for (i = 0; i < 12; i++) begin
         c = 4'(rnd());
         wr(`POS_REG_GPIO, {29'h0, c[2:0]});
         gpio_ext <= c[3];
         cyc(6);
         check(gpio_oe_n, exp_oe(c));
         rd(`POS_REG_STATUS);
         check(r[7], exp_pin(c));
      end
      wr(`POS_REG_GPIO, 32'h0000_0001);
      gpio_ext <= 1'b0;
      cyc(6);
      for (i = 0; i < 3; i++) begin
         m = 2'(2 - i);
         wr(`POS_REG_MASK, {27'h0, 3'b111, m});
         rd(`POS_REG_IRQ);
         gpio_ext <= 1'b1;
         cyc(6);
         check(irq_out_n_oe_n, m[0]);
         gpio_ext <= 1'b0;
         cyc(6);
         check(irq_out_n_oe_n, m[0] & m[1]);
         rd(`POS_REG_IRQ);
         check(r[1:0], 2'b11);
         cyc(3);
         check(irq_out_n_oe_n, 1'b1);
      end
      wr(`POS_REG_GPIO, 32'h0000_0009);
      rd(`POS_REG_IRQ);
      gpio_ext <= 1'b1;
      cyc(3);
      gpio_ext <= 1'b0;
      cyc(20);
      check(irq_out_n_oe_n, 1'b1);
      gpio_ext <= 1'b1;
      cyc(20);
      check(irq_out_n_oe_n, 1'b0);
      $display("test gpio done");
      tally_and_finish();
   end
endmodule // test_pos_supervisor

// ===== inc/pos_map.vh
/*
 Register offsets, field positions, reset values and timing counts of the
 on/off supervisor. Assumes a 25 MHz system clock and an APB register bus.
*/
`ifndef POS_MAP_VH
`define POS_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define POS_REG_CTRL      12'h000
`define POS_REG_STATUS    12'h004
`define POS_REG_IRQ       12'h008
`define POS_REG_MASK      12'h00C
`define POS_REG_GPIO      12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_CTRL_SWITCH   0
`define POS_CTRL_BIAS     1
`define POS_CTRL_SRST_LO  2
`define POS_CTRL_SRST_HI  3
`define POS_GPIO_DIR      0
`define POS_GPIO_DRIVE    1
`define POS_GPIO_DO       2
`define POS_GPIO_DBEN     3
`define POS_IRQ_GRISE     0
`define POS_IRQ_GFALL     1
`define POS_IRQ_KFALL     2
`define POS_IRQ_KRISE     3
`define POS_IRQ_W         4

// ----------------------------------------
// Reset values and commands
// ----------------------------------------
`define POS_CTRL_RST      4'h0
`define POS_MASK_RST      4'hF
`define POS_GPIO_RST      4'h1
`define POS_SRST_WAKE     2'h1
`define POS_SRST_COLD     2'h2
`define POS_SRST_OFF      2'h3

// ----------------------------------------
// Timing: time in its own unit, cycles at 25 MHz
// ----------------------------------------
`define POS_CLK_KHZ       25000
`define POS_HOLD_GF_US    100
`define POS_HOLD_GF_CYC   ((`POS_HOLD_GF_US * `POS_CLK_KHZ + 999) / 1000)
`define POS_DBNC_MS       30
`define POS_DBNC_CYC      (`POS_DBNC_MS * `POS_CLK_KHZ)
`define POS_CHG_DB_MS     120
`define POS_CHG_DB_CYC    (`POS_CHG_DB_MS * `POS_CLK_KHZ)
`define POS_MRST_S        16
`define POS_MRST_CYC      (`POS_MRST_S * 1000 * `POS_CLK_KHZ)
`define POS_HWAIT_MS      100
`define POS_HWAIT_CYC     (`POS_HWAIT_MS * `POS_CLK_KHZ)
`define POS_SEQ_STEP_CYC  25000
`define POS_SEQ_REGS      4

`endif

// ===== rtl/pos_supervisor.v
/*
 On/off supervisor: on-key, power hold, reset output, regulator sequencing,
 interrupt output and one GPIO, with an APB register slave.
 Assumes pins are asynchronous and pulled up externally for open-drain use.
*/
// Summary of operation
// - Out of reset the on-key works as a push-button; one selects slide-switch.
// - Interrupt pin pulls low while any unmasked interrupt bit is set.
// - All masks reset to masked; masked bits never move the interrupt pin.
// - Reset output releases a delay after the last regulator is enabled.
// - Reset output asserts before any regulator is turned off.
// - Power hold input passes a 100us glitch filter.
// - Combined hold is filtered hold ORed with valid charge input, drives the sequencer.
// - Without charge input, hold must rise within the wait time or power-down starts.
// - While on, hold low or soft cold-reset/off command starts power-down.
// - Valid charge input keeps combined hold asserted regardless of hold pin.
// - Direction cleared means output; set means output drivers off, input only.
// - As output, drive type one is push-pull, zero is open-drain.
// - GPIO input level bit follows the pin even when it is an output.
// - GPIO input has a 30ms debounce, enabled by one, bypassed by zero.
// - Separate rising and falling GPIO interrupts, each with its own mask.
// - On-key press powers up into hold check; hold high reaches on state.
// - In on state, hold going low powers down to standby.
// - Bias enable one moves standby to software-on; zero returns to standby.
// - A debounced on-key falling edge starts power-up in both key modes.
// - On-key held active for 16s while on forces power-down to standby.
// - Standby wakes on key falling edge, debounced charge rise, or soft wake flag.
`include "pos_map.vh"

module pos_supervisor #(
   parameter DBNC_CYC  = `POS_DBNC_CYC,
   parameter CHG_CYC   = `POS_CHG_DB_CYC,
   parameter MRST_CYC  = `POS_MRST_CYC,
   parameter HWAIT_CYC = `POS_HWAIT_CYC,
   parameter STEP_CYC  = `POS_SEQ_STEP_CYC
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        onkey_n,
   input  wire        power_hold_in,
   input  wire        charge_input,
   output reg         irq_out_n_oe_n,
   output reg         sys_reset_out_n_oe_n,
   output reg  [3:0]  reg_enable,
   output reg         main_bias_on,
   input  wire        gpio_in,
   output reg         gpio_out,
   output reg         gpio_oe_n
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_STANDBY = 3'd0;
   localparam ST_PWRUP   = 3'd1;
   localparam ST_RELDLY  = 3'd2;
   localparam ST_HOLDCHK = 3'd3;
   localparam ST_ON      = 3'd4;
   localparam ST_RSTLEAD = 3'd5;
   localparam ST_PWRDN   = 3'd6;
   localparam ST_SWON    = 3'd7;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   reg [3:0] sync_a;
   reg [3:0] sync_b;
   always @(posedge clk) begin
      if (!rst_n) begin
         sync_a <= 4'h9;
         sync_b <= 4'h9;
      end else begin
         sync_a <= {gpio_in, charge_input, power_hold_in, onkey_n};
         sync_b <= sync_a;
      end
   end
   wire key_s  = sync_b[0];
   wire hold_s = sync_b[1];
   wire chg_s  = sync_b[2];
   wire gpi_s  = sync_b[3];

   // ----------------------------------------
   // Filters: counters run only while input differs
   // ----------------------------------------
   reg        hold_f;
   reg [11:0] hold_cnt;
   always @(posedge clk) begin
      if (!rst_n) begin
         hold_f   <= 1'b0;
         hold_cnt <= 12'h000;
      end else if (hold_s == hold_f) begin
         hold_cnt <= 12'h000;
      end else if (hold_cnt == `POS_HOLD_GF_CYC - 1) begin
         hold_f   <= hold_s;
         hold_cnt <= 12'h000;
      end else begin
         hold_cnt <= hold_cnt + 12'h001;
      end
   end

   reg        key_f;
   reg        gpio_fall_irq;
   reg        chg_f;
   reg [23:0] key_cnt;
   reg [23:0] gpi_cnt;
   reg [23:0] chg_cnt;
   reg        gpi_dben;
   always @(posedge clk) begin
      if (!rst_n) begin
         key_f   <= 1'b1;
         gpio_fall_irq   <= 1'b1;
         chg_f   <= 1'b0;
         key_cnt <= 24'h00_0000;
         gpi_cnt <= 24'h00_0000;
         chg_cnt <= 24'h00_0000;
      end else begin
         if (key_s == key_f)
            key_cnt <= 24'h00_0000;
         else if (key_cnt == DBNC_CYC - 1) begin
            key_f   <= key_s;
            key_cnt <= 24'h00_0000;
         end else
            key_cnt <= key_cnt + 24'h00_0001;
         if (!gpi_dben) begin
            gpio_fall_irq   <= gpi_s;
            gpi_cnt <= 24'h00_0000;
         end else if (gpi_s == gpio_fall_irq)
            gpi_cnt <= 24'h00_0000;
         else if (gpi_cnt == DBNC_CYC - 1) begin
            gpio_fall_irq   <= gpi_s;
            gpi_cnt <= 24'h00_0000;
         end else
            gpi_cnt <= gpi_cnt + 24'h00_0001;
         if (chg_s == chg_f)
            chg_cnt <= 24'h00_0000;
         else if (chg_cnt == CHG_CYC - 1) begin
            chg_f   <= chg_s;
            chg_cnt <= 24'h00_0000;
         end else
            chg_cnt <= chg_cnt + 24'h00_0001;
      end
   end

   reg key_d;
   reg gpi_d;
   reg chg_d;
   always @(posedge clk) begin
      if (!rst_n) begin
         key_d <= 1'b1;
         gpi_d <= 1'b1;
         chg_d <= 1'b0;
      end else begin
         key_d <= key_f;
         gpi_d <= gpio_fall_irq;
         chg_d <= chg_f;
      end
   end
   wire key_fall = key_d & ~key_f;
   wire key_rise = ~key_d & key_f;
   wire gpi_rise = ~gpi_d & gpio_fall_irq;
   wire gpi_fall = gpi_d & ~gpio_fall_irq;
   wire chg_rise = ~chg_d & chg_f;
   // Charger level as valid-input indicator after debounce
   wire charge_input_valid  = chg_f;
   wire power_hold_combined = hold_f | charge_input_valid;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg        onkey_switch_type;
   reg        main_bias_sw_en;
   reg        gpio_direction;
   reg        gpio_drive_type;
   reg        gpio_data_out;
   reg [4:0]  irq_flags;
   reg [4:0]  irq_mask;
   reg        soft_wake_flag;
   reg        soft_off_req;
   reg [2:0]  state;

   wire wr     = psel & penable & pwrite;
   wire rd_ok  = (paddr == `POS_REG_CTRL) | (paddr == `POS_REG_STATUS) |
                 (paddr == `POS_REG_IRQ) | (paddr == `POS_REG_MASK) | (paddr == `POS_REG_GPIO);
   wire [1:0] srst = pwdata[`POS_CTRL_SRST_HI:`POS_CTRL_SRST_LO];
   wire irq_clr = psel & penable & ~pwrite & (paddr == `POS_REG_IRQ);
   wire [4:0] irq_evt = {1'b0, key_rise, key_fall, gpi_fall, gpi_rise};

   always @(posedge clk) begin
      if (!rst_n) begin
         onkey_switch_type <= 1'b0;
         main_bias_sw_en   <= 1'b0;
         gpio_direction    <= 1'b1;
         gpio_drive_type   <= 1'b0;
         gpio_data_out     <= 1'b0;
         gpi_dben          <= 1'b1;
         irq_mask          <= 5'h1F;
         irq_flags         <= 5'h00;
         soft_wake_flag    <= 1'b0;
         soft_off_req      <= 1'b0;
      end else begin
         // Clear on read only what was reported; later events survive
         irq_flags <= (irq_clr ? irq_flags & ~prdata[4:0] : irq_flags) | irq_evt;
         if (state == ST_STANDBY)
            soft_off_req <= 1'b0;
         if (state == ST_PWRUP)
            soft_wake_flag <= 1'b0;
         if (wr && paddr == `POS_REG_CTRL) begin
            onkey_switch_type <= pwdata[`POS_CTRL_SWITCH];
            main_bias_sw_en   <= pwdata[`POS_CTRL_BIAS];
            if (srst == `POS_SRST_WAKE)
               soft_wake_flag <= 1'b1;
            if (srst == `POS_SRST_COLD || srst == `POS_SRST_OFF)
               soft_off_req <= 1'b1;
            // Cold reset restarts via the wake flag
            if (srst == `POS_SRST_COLD)
               soft_wake_flag <= 1'b1;
         end
         if (wr && paddr == `POS_REG_MASK)
            irq_mask <= pwdata[4:0];
         if (wr && paddr == `POS_REG_GPIO) begin
            gpio_direction  <= pwdata[`POS_GPIO_DIR];
            gpio_drive_type <= pwdata[`POS_GPIO_DRIVE];
            gpio_data_out   <= pwdata[`POS_GPIO_DO];
            gpi_dben        <= pwdata[`POS_GPIO_DBEN];
         end
      end
   end

   // ----------------------------------------
   // APB slave: zero wait states
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~rd_ok;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `POS_REG_CTRL:   prdata <= {30'h0000_0000, main_bias_sw_en, onkey_switch_type};
               `POS_REG_STATUS: prdata <= {24'h00_0000, gpi_s, charge_input_valid, power_hold_combined,
                                           key_f, sys_reset_out_n_oe_n, state};
               `POS_REG_IRQ:    prdata <= {27'h000_0000, irq_flags};
               `POS_REG_MASK:   prdata <= {27'h000_0000, irq_mask};
               `POS_REG_GPIO:   prdata <= {28'h000_0000, gpi_dben, gpio_data_out, gpio_drive_type,
                                           gpio_direction};
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // On/off sequencer
   // ----------------------------------------
   reg [31:0] tmr;
   reg [2:0]  step;
   reg [31:0] mrst_cnt;
   wire key_active = onkey_switch_type ? key_f : ~key_f;
   wire wake = key_fall | chg_rise | soft_wake_flag;

   always @(posedge clk) begin
      if (!rst_n) begin
         mrst_cnt <= 32'h0000_0000;
      end else if (state == ST_ON && key_active) begin
         mrst_cnt <= mrst_cnt + 32'h0000_0001;
      end else begin
         mrst_cnt <= 32'h0000_0000;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state                <= ST_STANDBY;
         tmr                  <= 32'h0000_0000;
         step                 <= 3'd0;
         reg_enable           <= 4'h0;
         sys_reset_out_n_oe_n <= 1'b0;
         main_bias_on         <= 1'b0;
      end else begin
         tmr <= tmr + 32'h0000_0001;
         case (state)
            ST_STANDBY: begin
               tmr <= 32'h0000_0000;
               if (main_bias_sw_en) begin
                  state        <= ST_SWON;
                  main_bias_on <= 1'b1;
               end else if (wake) begin
                  state        <= ST_PWRUP;
                  main_bias_on <= 1'b1;
                  step         <= 3'd0;
               end
            end
            ST_PWRUP: if (tmr == STEP_CYC - 1) begin
               tmr             <= 32'h0000_0000;
               reg_enable[step[1:0]] <= 1'b1;
               step            <= step + 3'd1;
               if (step == `POS_SEQ_REGS - 1)
                  state <= ST_RELDLY;
            end
            ST_RELDLY: if (tmr == STEP_CYC - 1) begin
               tmr                  <= 32'h0000_0000;
               sys_reset_out_n_oe_n <= 1'b1;
               state                <= ST_HOLDCHK;
            end
            ST_HOLDCHK: begin
               if (power_hold_combined)
                  state <= ST_ON;
               else if (tmr >= HWAIT_CYC - 1 || soft_off_req) begin
                  state                <= ST_RSTLEAD;
                  sys_reset_out_n_oe_n <= 1'b0;
                  tmr                  <= 32'h0000_0000;
               end
            end
            ST_ON: begin
               tmr <= 32'h0000_0000;
               if (!power_hold_combined || soft_off_req || mrst_cnt >= MRST_CYC - 1) begin
                  state                <= ST_RSTLEAD;
                  sys_reset_out_n_oe_n <= 1'b0;
               end
            end
            ST_RSTLEAD: if (tmr == STEP_CYC - 1) begin
               tmr   <= 32'h0000_0000;
               step  <= 3'd0;
               state <= ST_PWRDN;
            end
            ST_PWRDN: if (tmr == STEP_CYC - 1) begin
               tmr  <= 32'h0000_0000;
               reg_enable[2'd3 - step[1:0]] <= 1'b0;
               step <= step + 3'd1;
               if (step == `POS_SEQ_REGS - 1) begin
                  state        <= ST_STANDBY;
                  main_bias_on <= 1'b0;
               end
            end
            ST_SWON: if (!main_bias_sw_en) begin
               state        <= ST_STANDBY;
               main_bias_on <= 1'b0;
            end
            default: state <= ST_STANDBY;
         endcase
      end
   end

   // ----------------------------------------
   // Pin drivers (oe_n low = pulling/driving)
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         irq_out_n_oe_n <= 1'b1;
         gpio_out       <= 1'b0;
         gpio_oe_n      <= 1'b1;
      end else begin
         irq_out_n_oe_n <= ~|(irq_flags & ~irq_mask);
         gpio_out       <= gpio_data_out;
         // Open-drain only drives the low level
         gpio_oe_n      <= gpio_direction | (~gpio_drive_type & gpio_data_out);
      end
   end

endmodule // pos_supervisor
